// ===== hdl/sram_port_regs.svh
// Timing constants for the asynchronous SRAM port controller.
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH
`define CLK_PERIOD_NS 10
`define T_ACCESS_NS 55
`define T_ACCESS_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WRITE_PULSE_NS 45
`define T_WRITE_PULSE_CYC \
	((`T_WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_TURN_NS 15
`define T_TURN_CYC ((`T_TURN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_CYCLE_NS 55
`define T_CYCLE_CYC ((`T_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W 13
`define DATA_W 8
`define CNT_W 4
`endif

// ===== hdl/sram_port_pkg.sv
// Types for the asynchronous SRAM port controller.
`include "sram_port_regs.svh"
package sram_port_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_read,
		st_wsetup,
		st_wpulse,
		st_wturn,
		st_recover
	} phase_type;

	typedef struct packed {
		phase_type phase;
		logic [`CNT_W-1:0] cnt;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
		logic [`DATA_W-1:0] rdata;
		logic chip_sel_n;
		logic write_n;
		logic out_drv_n;
		logic data_oe;
		logic rvalid;
		logic busy_s1;
		logic busy_s2;
		logic [`DATA_W-1:0] din_s1;
		logic [`DATA_W-1:0] din_s2;
	} state_type;
endpackage : sram_port_pkg

// ===== hdl/async_sram_rw_port.sv
// Host-side controller driving an asynchronous nonvolatile SRAM port.
// What this block does
// - Reads keep write strobe and store/busy line high throughout.
// - Writes keep the store/busy line high throughout.
// - Address changes only while chip select or write strobe is high.
// - Chip select held long enough before write termination.
// - Address stable long enough before write end; hold may be zero.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_regs.svh"
module async_sram_rw_port (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [`ADDR_W-1:0] req_addr_i,
	input wire logic [`DATA_W-1:0] req_wdata_i,
	output logic req_ready_o,
	output logic [`DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	output logic [`ADDR_W-1:0] word_index_in_o,
	output logic chip_sel_n_o,
	output logic write_n_o,
	output logic out_drv_n_o,
	input wire logic [`DATA_W-1:0] data_pins_i,
	output logic [`DATA_W-1:0] data_pins_o,
	output logic data_pins_oe_o,
	input wire logic hardware_store_busy_n_i,
	output logic hardware_store_busy_n_o,
	output logic hardware_store_busy_n_oe_o
);
	sram_port_pkg::state_type s;
	sram_port_pkg::state_type next_s;
	logic idle_ok;
	logic take_read;
	logic take_write;
	logic read_done;
	logic pulse_done;
	logic recover_done;

	// The controller never starts a store; the line is only watched.
	assign hardware_store_busy_n_o = 1'b1;
	assign hardware_store_busy_n_oe_o = 1'b0;

	// A low store/busy line blocks new accesses until it rises again.
	assign idle_ok = (s.phase == sram_port_pkg::st_idle) && s.busy_s2;
	assign req_ready_o = idle_ok;
	// A request is taken only in a cycle in which ready is high.
	assign take_read = req_valid_i && idle_ok && !req_write_i;
	assign take_write = req_valid_i && idle_ok && req_write_i;

	// Two extra cycles cover the pin synchroniser, so the byte taken has
	// stood on the pins for longer than the slowest access time.
	assign read_done = (s.cnt == `CNT_W'(`T_ACCESS_CYC + 2));
	// Whole periods rounded up keep select and address time above limit.
	assign pulse_done = (s.cnt == `CNT_W'(`T_WRITE_PULSE_CYC - 1));
	assign recover_done = (s.cnt >= `CNT_W'(`T_TURN_CYC));

	// Every pin and data output except the tied-off store/busy pair comes straight from a flip-flop.
	assign rdata_o = s.rdata;
	assign rvalid_o = s.rvalid;
	assign word_index_in_o = s.addr;
	assign chip_sel_n_o = s.chip_sel_n;
	assign write_n_o = s.write_n;
	assign out_drv_n_o = s.out_drv_n;
	assign data_pins_o = s.wdata;
	assign data_pins_oe_o = s.data_oe;

	// Each phase spells out all four pin controls, so a forgotten
	// branch cannot leave a strobe low or the data pins driven.
	always_comb begin
		next_s = s;
		// Both pin inputs pass two flip-flops before anything reads them.
		next_s.busy_s1 = hardware_store_busy_n_i;
		next_s.busy_s2 = s.busy_s1;
		next_s.din_s1 = data_pins_i;
		next_s.din_s2 = s.din_s1;
		next_s.rvalid = 1'b0;
		case (s.phase)
			sram_port_pkg::st_idle: begin
				// Nothing is selected; the address moves only here.
				next_s.chip_sel_n = 1'b1;
				next_s.write_n = 1'b1;
				next_s.out_drv_n = 1'b1;
				next_s.data_oe = 1'b0;
				next_s.cnt = '0;
				if (take_write) begin
					next_s.addr = req_addr_i;
					next_s.wdata = req_wdata_i;
					next_s.phase = sram_port_pkg::st_wsetup;
				end else if (take_read) begin
					next_s.addr = req_addr_i;
					next_s.chip_sel_n = 1'b0;
					next_s.out_drv_n = 1'b0;
					next_s.write_n = 1'b1;
					next_s.phase = sram_port_pkg::st_read;
				end else begin
					next_s.phase = sram_port_pkg::st_idle;
				end
			end

			sram_port_pkg::st_read: begin
				// The write strobe stays high for the whole read.
				next_s.chip_sel_n = 1'b0;
				next_s.write_n = 1'b1;
				next_s.out_drv_n = 1'b0;
				next_s.data_oe = 1'b0;
				next_s.cnt = s.cnt + 1'b1;
				if (read_done) begin
					// The byte comes from the second synchroniser stage.
					next_s.rdata = s.din_s2;
					next_s.rvalid = 1'b1;
					next_s.chip_sel_n = 1'b1;
					next_s.out_drv_n = 1'b1;
					next_s.cnt = '0;
					next_s.phase = sram_port_pkg::st_recover;
				end else begin
					next_s.phase = sram_port_pkg::st_read;
				end
			end

			sram_port_pkg::st_wsetup: begin
				// Output drive stays high through a write, so the part
				// never drives the pins while the controller does.
				next_s.out_drv_n = 1'b1;
				next_s.write_n = 1'b0;
				next_s.chip_sel_n = 1'b0;
				next_s.data_oe = 1'b1;
				next_s.cnt = '0;
				next_s.phase = sram_port_pkg::st_wpulse;
			end

			sram_port_pkg::st_wpulse: begin
				// Address and data stand still while both strobes are low.
				next_s.chip_sel_n = 1'b0;
				next_s.write_n = 1'b0;
				next_s.out_drv_n = 1'b1;
				next_s.data_oe = 1'b1;
				next_s.cnt = s.cnt + 1'b1;
				if (pulse_done) begin
					next_s.write_n = 1'b1;
					next_s.chip_sel_n = 1'b1;
					next_s.cnt = '0;
					next_s.phase = sram_port_pkg::st_wturn;
				end else begin
					next_s.phase = sram_port_pkg::st_wpulse;
				end
			end

			sram_port_pkg::st_wturn: begin
				// Data is held one period past the end of the write, then
				// released before the part may drive the pins again.
				next_s.chip_sel_n = 1'b1;
				next_s.write_n = 1'b1;
				next_s.out_drv_n = 1'b1;
				next_s.data_oe = 1'b0;
				next_s.phase = sram_port_pkg::st_recover;
			end

			sram_port_pkg::st_recover: begin
				// Idle periods here keep two accesses at least a cycle
				// time apart, whichever kind came first.
				next_s.chip_sel_n = 1'b1;
				next_s.write_n = 1'b1;
				next_s.out_drv_n = 1'b1;
				next_s.data_oe = 1'b0;
				next_s.cnt = s.cnt + 1'b1;
				if (recover_done) begin
					next_s.cnt = '0;
					next_s.phase = sram_port_pkg::st_idle;
				end else begin
					next_s.phase = sram_port_pkg::st_recover;
				end
			end

			default: begin
				// An unknown phase parks every strobe high and goes idle.
				next_s.chip_sel_n = 1'b1;
				next_s.write_n = 1'b1;
				next_s.out_drv_n = 1'b1;
				next_s.data_oe = 1'b0;
				next_s.cnt = '0;
				next_s.phase = sram_port_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s.phase <= sram_port_pkg::st_idle;
			s.cnt <= '0;
			s.addr <= '0;
			s.wdata <= '0;
			s.rdata <= '0;
			// Strobes park high and the data pins are released.
			s.chip_sel_n <= 1'b1;
			s.write_n <= 1'b1;
			s.out_drv_n <= 1'b1;
			s.data_oe <= 1'b0;
			s.rvalid <= 1'b0;

			// Busy synchroniser flops reset high, so ready need not wait.
			s.busy_s1 <= 1'b1;
			s.busy_s2 <= 1'b1;
			s.din_s1 <= '0;
			s.din_s2 <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : async_sram_rw_port
`default_nettype wire

// ===== bench/sram_port_checker_asserts.sv
// Pin timing checks for the SRAM port controller.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_regs.svh"
module sram_port_checker (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic req_ready_o,
	input wire logic rvalid_o,
	input wire logic [`ADDR_W-1:0] word_index_in_o,
	input wire logic chip_sel_n_o,
	input wire logic write_n_o,
	input wire logic out_drv_n_o,
	input wire logic data_pins_oe_o,
	input wire logic hardware_store_busy_n_i,
	input wire logic hardware_store_busy_n_oe_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	a_read_strobes: assert property (!out_drv_n_o |-> write_n_o &&
		!hardware_store_busy_n_oe_o) else $error("read strobes");
	a_write_store: assert property (!write_n_o |->
		!hardware_store_busy_n_oe_o) else $error("write store line");
	a_addr_hold: assert property (!chip_sel_n_o && !write_n_o &&
		$past(!chip_sel_n_o && !write_n_o) |-> $stable(word_index_in_o))
		else $error("address moved");
	a_select_width: assert property ($fell(write_n_o) |->
		!chip_sel_n_o [*5]) else $error("select short");
	a_addr_setup: assert property ($fell(write_n_o) |->
		$stable(word_index_in_o) [*5]) else $error("address setup");
	a_cycle_space: assert property ($fell(chip_sel_n_o) |=>
		!$fell(chip_sel_n_o) [*5]) else $error("cycle too short");
	a_busy_refuse: assert property (!hardware_store_busy_n_i |-> ##2
		!req_ready_o) else $error("ready while store busy");
	a_bus_contend: assert property (!out_drv_n_o |->
		!data_pins_oe_o) else $error("data pins contended");
	c_read: cover property ($rose(rvalid_o));
	c_write: cover property ($fell(write_n_o));
	c_refuse: cover property (!hardware_store_busy_n_i && !req_ready_o);
endmodule : sram_port_checker
bind async_sram_rw_port sram_port_checker u_sram_port_checker (
	.mclk_i(mclk_i),
	.srst_i(srst_i),
	.req_ready_o(req_ready_o),
	.rvalid_o(rvalid_o),
	.word_index_in_o(word_index_in_o),
	.chip_sel_n_o(chip_sel_n_o),
	.write_n_o(write_n_o),
	.out_drv_n_o(out_drv_n_o),
	.data_pins_oe_o(data_pins_oe_o),
	.hardware_store_busy_n_i(hardware_store_busy_n_i),
	.hardware_store_busy_n_oe_o(hardware_store_busy_n_oe_o)
);
`default_nettype wire

// ===== bench/sram_model.sv
// Behavioural model of the SRAM array and data pins.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_regs.svh"
module sram_model (
	input wire logic mclk_i,
	input wire logic [`ADDR_W-1:0] word_index_in_o,
	input wire logic chip_sel_n_o,
	input wire logic write_n_o,
	input wire logic out_drv_n_o,
	input wire logic hardware_store_busy_n_i,
	input wire logic [`DATA_W-1:0] data_pins_o,
	output logic [`DATA_W-1:0] data_pins_i
);
	logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
	logic [`DATA_W-1:0] drive = 8'h00;
	logic active;
	// A store in progress shuts the array off from the pins.
	assign active = !chip_sel_n_o && hardware_store_busy_n_i;
	assign data_pins_i = drive;
	// Released pins toggle, so a stale byte never passes for read data.
	always @(posedge mclk_i) begin
		drive <= (active && write_n_o && !out_drv_n_o) ?
			mem[word_index_in_o] : ~drive;
		if (active && !write_n_o)
			mem[word_index_in_o] <= data_pins_o;
	end
endmodule : sram_model
`default_nettype wire

// ===== bench/testbench.sv
// Directed tests of the SRAM port controller against the array model.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_regs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
	bad_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [`ADDR_W-1:0] req_addr_i = 13'h0000;
	logic [`DATA_W-1:0] req_wdata_i = 8'h00;
	logic hardware_store_busy_n_i = 1'b1;
	logic req_ready_o, rvalid_o, chip_sel_n_o, write_n_o, out_drv_n_o;
	logic data_pins_oe_o, hardware_store_busy_n_o, hardware_store_busy_n_oe_o;
	logic [`DATA_W-1:0] rdata_o, data_pins_i, data_pins_o;
	logic [`ADDR_W-1:0] word_index_in_o;
	int bad_count = 0;
	int samples_checked = 0;
	always #5 mclk_i = ~mclk_i;
	async_sram_rw_port u_async_sram_rw_port (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.req_valid_i(req_valid_i),
		.req_write_i(req_write_i),
		.req_addr_i(req_addr_i),
		.req_wdata_i(req_wdata_i),
		.req_ready_o(req_ready_o),
		.rdata_o(rdata_o),
		.rvalid_o(rvalid_o),
		.word_index_in_o(word_index_in_o),
		.chip_sel_n_o(chip_sel_n_o),
		.write_n_o(write_n_o),
		.out_drv_n_o(out_drv_n_o),
		.data_pins_i(data_pins_i),
		.data_pins_o(data_pins_o),
		.data_pins_oe_o(data_pins_oe_o),
		.hardware_store_busy_n_i(hardware_store_busy_n_i),
		.hardware_store_busy_n_o(hardware_store_busy_n_o),
		.hardware_store_busy_n_oe_o(hardware_store_busy_n_oe_o)
	);
	sram_model u_sram_model (
		.mclk_i(mclk_i),
		.word_index_in_o(word_index_in_o),
		.chip_sel_n_o(chip_sel_n_o),
		.write_n_o(write_n_o),
		.out_drv_n_o(out_drv_n_o),
		.hardware_store_busy_n_i(hardware_store_busy_n_i),
		.data_pins_o(data_pins_o),
		.data_pins_i(data_pins_i)
	);
	task end_sim;
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge mclk_i);
		while (req_ready_o !== 1'b1 && n < 99) begin
			@(negedge mclk_i);
			n++;
		end
		`CHK("ready", 1'b1, req_ready_o)
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		req_write_i <= w;
		req_addr_i <= a;
		req_wdata_i <= d;
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		n = 0;
		while (!w && rvalid_o !== 1'b1 && n < 20) begin
			@(negedge mclk_i);
			n++;
		end
		if (!w) begin
			`CHK("rvalid", 1'b1, rvalid_o)
			`CHK("rdata", d, rdata_o)
		end
	endtask : xfer
	task t_boundary;
		xfer(1'b1, 13'h0000, 8'ha5);
		xfer(1'b1, 13'h1fff, 8'h5a);
		xfer(1'b0, 13'h0000, 8'ha5);
		xfer(1'b0, 13'h1fff, 8'h5a);
	endtask : t_boundary
	task t_store_busy;
		@(posedge mclk_i);
		hardware_store_busy_n_i <= 1'b0;
		repeat (12) @(negedge mclk_i);
		`CHK("ready", 1'b0, req_ready_o)
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		req_write_i <= 1'b1;
		req_addr_i <= 13'h0000;
		req_wdata_i <= 8'hff;
		repeat (4) @(negedge mclk_i);
		`CHK("select", 1'b1, chip_sel_n_o)
		`CHK("data drive", 1'b0, data_pins_oe_o)
		`CHK("store level", 1'b1, hardware_store_busy_n_o)
		`CHK("store drive", 1'b0, hardware_store_busy_n_oe_o)
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		hardware_store_busy_n_i <= 1'b1;
		xfer(1'b0, 13'h0000, 8'ha5);
	endtask : t_store_busy
	initial begin
		repeat (5) @(posedge mclk_i);
		srst_i <= 1'b0;
		t_boundary;
		t_store_busy;
		end_sim;
	end
	// About a hundred cycles of work; twenty times that means a hang.
	initial begin
		#20000;
		bad_count++;
		end_sim;
	end
endmodule : testbench
`default_nettype wire
